/* head_pos_pkg.sv */
// Functional notes
// [RULE1] Command bit 3 set loads the head at start; clear unloads it.
// [RULE2] Head stays loaded until two idle revolutions pass.
// [RULE3] Engaged input sampled only before verify, after the settle delay.
// [RULE4] Command bit 2 requests a verify of the final track.
// [RULE5] Rate field 00/01 gives 6 ms, 10 gives 10 ms, 11 gives 20 ms.
// [RULE6] Half-rate mode doubles intervals; test input low gives about 400 us.
// [RULE7] Verify loads head, waits, samples engaged, reads ID, compares track.
// [RULE8] Good CRC and matching track ends the command with interrupt.
// [RULE9] Good CRC, wrong track: seek error, end with interrupt.
// [RULE10] Bad ID CRC sets CRC error and the next ID field is checked.
// [RULE11] No good ID in four revolutions ends with interrupt.
// [RULE12] Bit 4 makes step commands update the track register.
// [RULE13] Restore steps out until track zero, then clears track register.
// [RULE14] Restore stops after 255 steps with seek error.
// [RULE15] Reset release starts a restore.
// [RULE16] Seek steps toward the data register, updating the track register.
// [RULE17] Step issues one pulse in the previous direction, then interrupts.
// [RULE18] Step-in: one inward pulse, track register incremented if updating.
// [RULE19] Step-out: one outward pulse, track register decremented if updating.
// [RULE20] Each single step waits the rate interval, then verifies if asked.
// [RULE21] Bits 7..4 decode restore, seek, step, step-in, step-out; busy while running.
// [RULE22] Step-direction mode: direction high for in, 4 us high step pulse.
// [RULE23] Three-phase mode sequences 1-2-3 inward and 1-3-2 outward.
package head_pos_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_CMD_STATUS = 2'h0;
  localparam logic [1:0] OFS_TRACK      = 2'h1;
  localparam logic [1:0] OFS_DATA       = 2'h3;
  localparam logic [7:0] CMD_RESET      = 8'h00;
  localparam logic [7:0] TRACK_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam int         CMD_TYPE_BIT   = 7;
  localparam int         CMD_U_BIT      = 4;
  localparam int         CMD_H_BIT      = 3;
  localparam int         CMD_V_BIT      = 2;
  localparam logic [3:0] OP_RESTORE     = 4'h0;
  localparam logic [3:0] OP_SEEK        = 4'h1;
  localparam logic [1:0] FAM_IN         = 2'h2;
  localparam logic [1:0] FAM_OUT        = 2'h3;
  localparam int         ST_BUSY        = 0;
  localparam int         ST_INDEX       = 1;
  localparam int         ST_TRACK0      = 2;
  localparam int         ST_CRC         = 3;
  localparam int         ST_SEEK        = 4;
  localparam int         ST_HEAD        = 5;

  // ----------------------------------------------------------------
  // Counts and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] MAX_RESTORE_STEPS = 8'hFF;
  localparam logic [2:0] UNLOAD_REVS       = 3'h2;
  localparam logic [2:0] VERIFY_REVS       = 3'h4;
  localparam int         CLK_MHZ           = 100;
  localparam int         STEP_6_MS         = 6;
  localparam int         STEP_10_MS        = 10;
  localparam int         STEP_20_MS        = 20;
  localparam int         TEST_STEP_US      = 400;
  localparam int         SETTLE_MS         = 10;
  localparam int         STEP_PULSE_US     = 4;
  localparam int         STEP_6_CYC        = STEP_6_MS * 1000 * CLK_MHZ;
  localparam int         STEP_10_CYC       = STEP_10_MS * 1000 * CLK_MHZ;
  localparam int         STEP_20_CYC       = STEP_20_MS * 1000 * CLK_MHZ;
  localparam int         TEST_STEP_CYC     = TEST_STEP_US * CLK_MHZ;
  localparam int         SETTLE_CYC        = SETTLE_MS * 1000 * CLK_MHZ;
  localparam int         STEP_PULSE_CYC    = STEP_PULSE_US * CLK_MHZ;
  localparam int         TIMER_W           = 24;

  typedef enum logic [2:0] {
    IDLE, CHECK, STEP, WAIT_STEP, END_POS, SETTLE, VERIFY, DONE
  } state_t;

endpackage : head_pos_pkg

/* interval_timer.sv */
`timescale 1ns/1ps
// Down counter: done pulses load + 1 cycles after the start pulse.
module interval_timer #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              done
);

  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      done <= !start && (count == W'(1));
      if (start)
        count <= load;
      else if (count != '0)
        count <= count - W'(1);
    end
  end

endmodule : interval_timer

/* motor_drive.sv */
`timescale 1ns/1ps
// Turns one-cycle step requests into step-direction or three-phase levels.
module motor_drive (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic step_req,
  input  wire logic dir_in,
  input  wire logic three_phase_select_n,
  output logic      phase1_or_step_out,
  output logic      phase2_or_direction_out,
  output logic      phase3_out
);
  import head_pos_pkg::*;

  localparam logic [9:0] PULSE_LEN = 10'(STEP_PULSE_CYC);

  logic [1:0] phase;
  logic [9:0] pulse_count;
  logic       step_q;

  wire        three_phase = !three_phase_select_n;
  wire [1:0]  phase_in    = (phase == 2'd2) ? 2'd0 : phase + 2'd1;
  wire [1:0]  phase_out   = (phase == 2'd0) ? 2'd2 : phase - 2'd1;

  // The pulse starts two cycles after the direction level so the drive sees direction settled first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q      <= 1'b0;
      pulse_count <= '0;
      phase       <= 2'd0;
    end else begin
      step_q <= step_req;
      if (step_q)
        pulse_count <= PULSE_LEN; // RULE22
      else if (pulse_count != '0)
        pulse_count <= pulse_count - 10'd1;
      if (step_q)
        phase <= dir_in ? phase_in : phase_out; // RULE23
    end
  end

  // Phase 1 and 2 are active low, phase 3 active high; phase 1 is active after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase1_or_step_out      <= 1'b0;
      phase2_or_direction_out <= 1'b0;
      phase3_out              <= 1'b0;
    end else if (three_phase) begin
      phase1_or_step_out      <= phase != 2'd0; // RULE23
      phase2_or_direction_out <= phase != 2'd1;
      phase3_out              <= phase == 2'd2;
    end else begin
      phase1_or_step_out      <= pulse_count != '0; // RULE22
      phase2_or_direction_out <= dir_in;
      phase3_out              <= 1'b0;
    end
  end

endmodule : motor_drive

/* head_positioning_sequencer.sv */
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module head_positioning_sequencer #(
  parameter int STEP_6_CYC_P    = head_pos_pkg::STEP_6_CYC,
  parameter int STEP_10_CYC_P   = head_pos_pkg::STEP_10_CYC,
  parameter int STEP_20_CYC_P   = head_pos_pkg::STEP_20_CYC,
  parameter int TEST_STEP_CYC_P = head_pos_pkg::TEST_STEP_CYC,
  parameter int SETTLE_CYC_P    = head_pos_pkg::SETTLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       track_zero_in,
  input  wire logic       head_engaged_in,
  input  wire logic       index_pulse_n,
  input  wire logic       test_n,
  input  wire logic       half_rate_sel,
  input  wire logic       three_phase_select_n,
  input  wire logic       id_valid,
  input  wire logic [7:0] id_track,
  input  wire logic       id_crc_ok,
  output logic            id_read_req,
  output logic            head_load_out,
  output logic            interrupt_request,
  output logic            phase1_or_step_out,
  output logic            phase2_or_direction_out,
  output logic            phase3_out
);
  import head_pos_pkg::*;

  localparam logic [TIMER_W-1:0] C_6      = TIMER_W'(STEP_6_CYC_P);
  localparam logic [TIMER_W-1:0] C_10     = TIMER_W'(STEP_10_CYC_P);
  localparam logic [TIMER_W-1:0] C_20     = TIMER_W'(STEP_20_CYC_P);
  localparam logic [TIMER_W-1:0] C_TEST   = TIMER_W'(TEST_STEP_CYC_P);
  localparam logic [TIMER_W-1:0] C_SETTLE = TIMER_W'(SETTLE_CYC_P);

  state_t               state;
  logic [7:0]           cmd;
  logic [7:0]           track;
  logic [7:0]           data_target;
  logic [7:0]           step_count;
  logic                 busy;
  logic                 crc_err;
  logic                 seek_err;
  logic                 last_dir;
  logic                 stepped;
  logic                 restore_pending;
  logic                 step_pulse;
  logic                 index_q;
  logic [2:0]           rev_count;
  logic                 timer_start;
  logic [TIMER_W-1:0]   timer_load;
  logic                 timer_done;
  logic [7:0]           status;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire                 cmd_wr       = wr_en && (addr == OFS_CMD_STATUS);
  wire                 status_rd    = rd_en && (addr == OFS_CMD_STATUS);
  wire                 track_wr     = wr_en && (addr == OFS_TRACK) && !busy;
  wire                 data_wr      = wr_en && (addr == OFS_DATA) && !busy;
  // Other command groups belong to other blocks.
  wire                 accept       = cmd_wr && !busy && !wdata[CMD_TYPE_BIT]; // RULE21
  wire [3:0]           opcode       = cmd[7:4];
  wire [1:0]           family       = cmd[6:5];
  wire                 is_restore   = opcode == OP_RESTORE; // RULE21
  wire                 is_seek      = opcode == OP_SEEK;
  wire                 is_single    = !is_restore && !is_seek;
  wire                 track_update = is_seek || (is_single && cmd[CMD_U_BIT]); // RULE12
  wire                 next_dir     = is_restore          ? 1'b0 :
                                      is_seek             ? (data_target > track) : // RULE16
                                      family == FAM_IN    ? 1'b1 : // RULE18
                                      family == FAM_OUT   ? 1'b0 : // RULE19
                                      last_dir; // RULE17
  wire [7:0]           next_track   = next_dir ? track + 8'd1 : track - 8'd1;
  wire                 index_fall   = index_q && !index_pulse_n;
  wire [TIMER_W-1:0]   base_cyc     = !test_n ? C_TEST : // RULE6
                                      !cmd[1] ? C_6 : // RULE5
                                      cmd[0]  ? C_20 : C_10;
  // Half rate models a slow part clock.
  wire [TIMER_W-1:0]   rate_cyc     = half_rate_sel ? {base_cyc[TIMER_W-2:0], 1'b0} : base_cyc; // RULE6
  wire                 unload_due   = (rev_count == UNLOAD_REVS);
  wire                 verify_lost  = (rev_count == VERIFY_REVS);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= IDLE;
      cmd             <= CMD_RESET;
      track           <= TRACK_RESET;
      busy            <= 1'b0;
      crc_err         <= 1'b0;
      seek_err        <= 1'b0;
      head_load_out   <= 1'b0;
      last_dir        <= 1'b0;
      stepped         <= 1'b0;
      step_count      <= 8'h00;
      restore_pending <= 1'b1;
      step_pulse      <= 1'b0;
      timer_start     <= 1'b0;
      timer_load      <= '0;
      id_read_req     <= 1'b0;
    end else begin
      step_pulse  <= 1'b0;
      timer_start <= 1'b0;
      if (track_wr)
        track <= wdata;
      case (state)
        IDLE: begin
          if (restore_pending) begin
            restore_pending <= 1'b0; // RULE15
            cmd             <= CMD_RESET;
            busy            <= 1'b1;
            crc_err         <= 1'b0;
            seek_err        <= 1'b0;
            stepped         <= 1'b0;
            step_count      <= 8'h00;
            head_load_out   <= 1'b0;
            state           <= CHECK;
          end else if (accept) begin
            cmd             <= wdata;
            busy            <= 1'b1; // RULE21
            crc_err         <= 1'b0;
            seek_err        <= 1'b0;
            stepped         <= 1'b0;
            step_count      <= 8'h00;
            head_load_out   <= wdata[CMD_H_BIT]; // RULE1
            state           <= CHECK;
          end else if (head_load_out && unload_due) begin
            head_load_out   <= 1'b0; // RULE2
          end
        end
        CHECK: begin
          if (is_restore) begin
            if (!track_zero_in) begin
              track <= TRACK_RESET; // RULE13
              state <= END_POS;
            end else if (step_count == MAX_RESTORE_STEPS) begin
              seek_err <= 1'b1; // RULE14
              state    <= DONE;
            end else begin
              state <= STEP; // RULE13
            end
          end else if (is_seek) begin
            state <= (track == data_target) ? END_POS : STEP; // RULE16
          end else begin
            state <= stepped ? END_POS : STEP; // RULE17
          end
        end
        STEP: begin
          step_pulse  <= 1'b1;
          last_dir    <= next_dir;
          stepped     <= 1'b1;
          step_count  <= step_count + 8'd1;
          if (track_update)
            track <= next_track; // RULE12
          timer_load  <= rate_cyc; // RULE20
          timer_start <= 1'b1;
          state       <= WAIT_STEP;
        end
        WAIT_STEP: begin
          if (timer_done)
            state <= CHECK; // RULE20
        end
        END_POS: begin
          if (cmd[CMD_V_BIT]) begin
            head_load_out <= 1'b1; // RULE7
            timer_load    <= C_SETTLE;
            timer_start   <= 1'b1;
            state         <= SETTLE; // RULE4
          end else begin
            state <= DONE; // RULE4
          end
        end
        SETTLE: begin
          // The engaged input is looked at only when the settle delay has run out.
          if (timer_done) begin
            if (head_engaged_in) begin
              id_read_req <= 1'b1; // RULE3
              state       <= VERIFY;
            end else begin
              timer_start <= 1'b1; // RULE3
            end
          end
        end
        VERIFY: begin
          if (id_valid && id_crc_ok) begin
            seek_err    <= (id_track != track); // RULE9
            id_read_req <= 1'b0;
            state       <= DONE; // RULE8
          end else if (id_valid) begin
            crc_err <= 1'b1; // RULE10
          end else if (verify_lost) begin
            id_read_req <= 1'b0; // RULE11
            state       <= DONE;
          end
        end
        DONE: begin
          busy  <= 1'b0; // RULE8
          state <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Revolution counting from the index pulse
  // ----------------------------------------------------------------
  // Counting restarts in busy states outside verify, so the idle count
  // measures idle time and the verify count the search time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q   <= 1'b1;
      rev_count <= 3'h0;
    end else begin
      index_q <= index_pulse_n;
      if (state != IDLE && state != VERIFY)
        rev_count <= 3'h0;
      else if (index_fall && rev_count != 3'h7)
        rev_count <= rev_count + 3'h1; // RULE2 RULE11
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Completion wins over a same-cycle clear, so none is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      interrupt_request <= 1'b0;
    else if (state == DONE)
      interrupt_request <= 1'b1; // RULE8 RULE9 RULE11 RULE13 RULE14
    else if (status_rd || accept)
      interrupt_request <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Data register and read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      data_target <= DATA_RESET;
    else if (data_wr)
      data_target <= wdata;
  end

  always_comb begin
    status           = 8'h00;
    status[ST_BUSY]  = busy;
    status[ST_INDEX] = !index_pulse_n;
    status[ST_TRACK0] = !track_zero_in;
    status[ST_CRC]   = crc_err;
    status[ST_SEEK]  = seek_err;
    status[ST_HEAD]  = head_load_out;
  end

  wire [7:0] read_mux = (addr == OFS_CMD_STATUS) ? status :
                        (addr == OFS_TRACK)      ? track :
                        (addr == OFS_DATA)       ? data_target : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata <= 8'h00;
    else
      rdata <= rd_en ? read_mux : 8'h00;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  interval_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (timer_start),
    .load  (timer_load),
    .done  (timer_done)
  );

  motor_drive u_motor (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .step_req                (step_pulse),
    .dir_in                  (last_dir),
    .three_phase_select_n    (three_phase_select_n),
    .phase1_or_step_out      (phase1_or_step_out),
    .phase2_or_direction_out (phase2_or_direction_out),
    .phase3_out              (phase3_out)
  );

endmodule : head_positioning_sequencer

/* floppy_drive_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Drive mechanism: head position, index, engage and ID fields.
// ----------------------------------------------------------------
module floppy_drive_model #(
  parameter int REV   = 2000,
  parameter int START = 3
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       step_in,
  input  wire logic       dir_in,
  input  wire logic       head_load_in,
  input  wire logic       search_in,
  input  wire logic       tz_stuck,
  input  wire logic       no_id,
  input  wire logic [1:0] bad_ids,
  output logic      [7:0] pos,
  output logic            track_zero_in,
  output logic            head_engaged_in,
  output logic            index_pulse_n,
  output logic            id_valid,
  output logic      [7:0] id_track,
  output logic            id_crc_ok
);
  int         rc;
  int         ic;
  int         hc;
  logic       st_q;
  logic [1:0] seen;
  wire        id_now = search_in && !no_id && (ic % 200 == 199);
  assign track_zero_in   = (pos != 8'h00) || tz_stuck;
  assign index_pulse_n   = rc >= 20;
  // Engage follows head load after a mechanical delay.
  assign head_engaged_in = hc >= 50;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 8'(START);
      rc <= 0;
      ic <= 0;
      hc <= 0;
      st_q <= 1'b0;
      seen <= 2'h0;
      id_valid <= 1'b0;
      id_track <= 8'h00;
      id_crc_ok <= 1'b0;
    end else begin
      rc <= (rc == REV - 1) ? 0 : rc + 1;
      hc <= head_load_in ? hc + 1 : 0;
      st_q <= step_in;
      if (step_in && !st_q) begin
        // The carriage stops at track zero.
        pos <= dir_in ? pos + 8'h01 : ((pos == 8'h00) ? 8'h00 : pos - 8'h01);
      end
      ic <= search_in ? ic + 1 : 0;
      id_valid <= id_now;
      if (id_now) begin
        id_track <= pos;
        id_crc_ok <= seen >= bad_ids;
        seen <= seen + 2'h1;
      end else begin
        id_track <= ~id_track;
        id_crc_ok <= ~id_crc_ok;
      end
      if (!search_in) begin
        seen <= 2'h0;
      end
    end
  end
endmodule : floppy_drive_model

/* head_pos_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the positioning sequencer.
// ----------------------------------------------------------------
module head_pos_checker #(
  parameter int SETTLE_CYC_P = 15
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       index_pulse_n,
  input wire logic       three_phase_select_n,
  input wire logic       head_engaged_in,
  input wire logic       id_read_req,
  input wire logic       head_load_out,
  input wire logic       interrupt_request,
  input wire logic       phase1_or_step_out,
  input wire logic       phase2_or_direction_out
);
  logic       idle;
  logic [8:0] wid;
  logic [1:0] nf;
  int         hl;
  wire        cmd = idle && wr_en && addr == 2'h0 && !wdata[7];
  wire        sr  = rd_en && addr == 2'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Idle starts at the interrupt, so the reset restore counts as busy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle <= 1'b0;
      wid <= 9'h000;
      nf <= 2'h0;
      hl <= 0;
    end else begin
      idle <= cmd ? 1'b0 : (interrupt_request ? 1'b1 : idle);
      wid <= (phase1_or_step_out && three_phase_select_n) ? wid + 9'h001 : 9'h000;
      nf <= (!idle || cmd) ? 2'h0 : ($fell(index_pulse_n) && nf != 2'h3 ? nf + 2'h1 : nf);
      hl <= head_load_out ? hl + 1 : 0;
    end
  end
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("read data not idle");
  a_pulse_width: assert property ($fell(phase1_or_step_out) && three_phase_select_n |-> wid == 9'h190)
    else $error("step pulse width wrong");
  a_head_cmd: assert property (cmd |-> ##2 head_load_out == $past(wdata[3], 2))
    else $error("head load flag ignored");
  a_irq_cmd: assert property (cmd |-> ##2 !interrupt_request) else $error("interrupt not cleared");
  a_dir_set: assert property (cmd && wdata[7:6] == 2'h1 && three_phase_select_n
    |-> ##6 phase2_or_direction_out == !$past(wdata[5], 6)) else $error("direction line wrong");
  a_no_step: assert property (idle && three_phase_select_n |-> !$rose(phase1_or_step_out))
    else $error("step pulse while idle");
  a_irq_hold: assert property (interrupt_request && !sr && !(wr_en && addr == 2'h0) |=> interrupt_request)
    else $error("interrupt dropped");
  a_head_unload: assert property (idle && nf == 2'h2 |-> ##[0:3] !head_load_out)
    else $error("head not unloaded");
  a_settle_engaged: assert property ($rose(id_read_req) |-> head_engaged_in && hl >= SETTLE_CYC_P)
    else $error("search too early");
  a_verify_head: assert property (id_read_req |-> head_load_out) else $error("search without head");
  c_cmd: cover property (cmd);
  c_search: cover property ($rose(id_read_req));
  c_pulse: cover property ($fell(phase1_or_step_out));
endmodule : head_pos_checker

bind head_positioning_sequencer head_pos_checker #(.SETTLE_CYC_P(SETTLE_CYC_P)) u_chk (
  .clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .index_pulse_n, .three_phase_select_n, .head_engaged_in,
  .id_read_req, .head_load_out, .interrupt_request, .phase1_or_step_out, .phase2_or_direction_out);

/* test_head_positioning_sequencer.sv */
`timescale 1ns/1ps
module test_head_positioning_sequencer;
  logic       clk, rst_n, wr_en, rd_en, test_n, half_rate_sel, tz_stuck, no_id, ph1, ph2;
  logic [1:0] addr, bad_ids;
  logic [7:0] wdata, rdata, id_track, pos, d;
  logic       track_zero_in, head_engaged_in, index_pulse_n, id_valid, id_crc_ok, id_read_req;
  logic       head_load_out, interrupt_request, three_phase_select_n;
  int         n_mismatch, num_checks, cyc, nsteps;
  int         ex[7] = '{600, 600, 700, 800, 402, 804, 1600};
  int         rt[7] = '{0, 1, 2, 3, 0, 0, 3};
  logic [6:0] tn = 7'h4F;
  logic [6:0] hr = 7'h60;
  logic [7:0] sc[5] = '{8'h78, 8'h38, 8'h58, 8'h38, 8'h68};
  logic [7:0] st[5] = '{8'h06, 8'h05, 8'h06, 8'h07, 8'h07};
  logic [7:0] sp[5] = '{8'h06, 8'h05, 8'h06, 8'h07, 8'h06};
  head_positioning_sequencer #(.STEP_6_CYC_P(600), .STEP_10_CYC_P(700), .STEP_20_CYC_P(800),
    .TEST_STEP_CYC_P(402), .SETTLE_CYC_P(300)) DUT (
    .clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .track_zero_in, .head_engaged_in, .index_pulse_n,
    .test_n, .half_rate_sel, .three_phase_select_n, .id_valid, .id_track, .id_crc_ok, .id_read_req,
    .head_load_out, .interrupt_request, .phase1_or_step_out(ph1), .phase2_or_direction_out(ph2), .phase3_out());
  floppy_drive_model drive (.clk, .rst_n, .step_in(ph1), .dir_in(ph2), .head_load_in(head_load_out),
    .search_in(id_read_req), .tz_stuck, .no_id, .bad_ids, .pos, .track_zero_in, .head_engaged_in,
    .index_pulse_n, .id_valid, .id_track, .id_crc_ok);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge ph1) nsteps++;
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Waits for the interrupt, then reads status into d, which clears it.
  task wait_irq(input int lim);
    cyc = 0;
    while (interrupt_request !== 1'b1) begin
      @(posedge clk);
      #1 cyc++;
      if (cyc > lim) begin
        n_mismatch++;
        conclude();
      end
    end
    rd(2'h0);
  endtask : wait_irq
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_n, wr_en, rd_en, half_rate_sel, tz_stuck, no_id} = 6'h00;
    {addr, bad_ids, wdata, test_n} = 13'h0001;
    {n_mismatch, num_checks, nsteps} = '0;
    three_phase_select_n = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_irq(5000);
    check(pos, 8'h00);
    rd(2'h1); check(d, 8'h00);
    wr(2'h2, 8'h5A); rd(2'h2); check(d, 8'h00);
    for (int i = 0; i < 7; i++) begin
      test_n <= tn[i];
      half_rate_sel <= hr[i];
      wr(2'h0, 8'h48 | 8'(rt[i]));
      wait_irq(2000);
      check({7'h00, cyc >= ex[i] && cyc <= ex[i] + 30}, 8'h01);
      check({7'h00, head_load_out}, 8'h01);
    end
    check(pos, 8'h07);
    rd(2'h1); check(d, 8'h00);
    test_n <= 1'b0;
    half_rate_sel <= 1'b0;
    wr(2'h1, 8'h07);
    for (int i = 0; i < 5; i++) begin
      wr(2'h0, sc[i]);
      wait_irq(2000);
      rd(2'h1); check(d, st[i]);
      check(pos, sp[i]);
    end
    wr(2'h1, 8'h06); wr(2'h3, 8'h02); wr(2'h0, 8'h18); wait_irq(5000);
    rd(2'h1); check(d, 8'h02);
    wr(2'h3, 8'h05); wr(2'h0, 8'h18); wait_irq(5000);
    rd(2'h1); check(d, 8'h05);
    check(pos, 8'h05);
    bad_ids <= 2'h2;
    wr(2'h1, 8'h03); wr(2'h3, 8'h03); wr(2'h0, 8'h1C); wait_irq(5000);
    check(d & 8'h19, 8'h18);
    check({7'h00, cyc >= 300}, 8'h01);
    bad_ids <= 2'h0;
    wr(2'h1, 8'h05); wr(2'h3, 8'h05); wr(2'h0, 8'h1C); wait_irq(5000);
    check(d & 8'h11, 8'h00);
    no_id <= 1'b1;
    wr(2'h0, 8'h1C); wait_irq(12000);
    check({7'h00, cyc >= 6000}, 8'h01);
    check(d & 8'h11, 8'h00);
    no_id <= 1'b0;
    wr(2'h0, 8'h10); wait_irq(5000);
    check({7'h00, head_load_out}, 8'h00);
    wr(2'h0, 8'h18); wait_irq(5000);
    cyc = 0;
    while (head_load_out !== 1'b0 && cyc < 7000) begin
      @(posedge clk);
      #1 cyc++;
    end
    check({7'h00, cyc >= 1990 && cyc < 7000}, 8'h01);
    tz_stuck <= 1'b1;
    nsteps = 0;
    wr(2'h0, 8'h00); wait_irq(110000);
    check(d & 8'h11, 8'h10);
    check(8'(nsteps), 8'hFF);
    conclude();
  end
endmodule : test_head_positioning_sequencer
